// [pkg/srg_defines.vh]
// Constants for the operation and questionable status register groups.
`ifndef SRG_DEFINES_VH
`define SRG_DEFINES_VH
`define SRG_WIDTH 16
`define SRG_CMD_W 4
`define SRG_CMD_NOP 4'h0
`define SRG_CMD_WR_OPERATION_SUMMARY_BIT_ENAB 4'h1
`define SRG_CMD_WR_OPERATION_SUMMARY_BIT_FALL 4'h2
`define SRG_CMD_WR_OPERATION_SUMMARY_BIT_RISE 4'h3
`define SRG_CMD_WR_QUESTIONABLE_SUMMARY_BIT_ENAB 4'h4
`define SRG_CMD_WR_QUESTIONABLE_SUMMARY_BIT_FALL 4'h5
`define SRG_CMD_WR_QUESTIONABLE_SUMMARY_BIT_RISE 4'h6
`define SRG_CMD_RD_OPERATION_SUMMARY_BIT_EVENT 4'h7
`define SRG_CMD_RD_OPERATION_SUMMARY_BIT_COND 4'h8
`define SRG_CMD_RD_OPERATION_SUMMARY_BIT_ENAB 4'h9
`define SRG_CMD_RD_OPERATION_SUMMARY_BIT_FALL 4'ha
`define SRG_CMD_RD_OPERATION_SUMMARY_BIT_RISE 4'hb
`define SRG_CMD_RD_QUESTIONABLE_SUMMARY_BIT_EVENT 4'hc
`define SRG_CMD_RD_QUESTIONABLE_SUMMARY_BIT_COND 4'hd
`define SRG_CMD_RD_QUESTIONABLE_SUMMARY_BIT_ENAB 4'he
`define SRG_CMD_RD_QUESTIONABLE_SUMMARY_BIT_FALL 4'hf
`define SRG_RST_FILTER 16'h0000
`define SRG_RST_ENAB 16'h0000
`define SRG_RST_EVENT 16'h0000
`define SRG_PRESET_RISE 16'hffff
`define SRG_PRESET_FALL 16'h0000
`define SRG_PRESET_ENAB 16'h0000
`endif

// [rtl/srg_status_groups.v]
// Operation and questionable status groups with filters, latches and masks.
`timescale 1ns/1ps
`include "srg_defines.vh"
module srg_status_groups #(
    parameter WIDTH = `SRG_WIDTH
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire clk_en_i,
    input wire [WIDTH-1:0] operation_summary_bit_cond_src_i,
    input wire [WIDTH-1:0] questionable_summary_bit_cond_src_i,
    input wire cmd_valid_i,
    input wire [`SRG_CMD_W-1:0] cmd_code_i,
    input wire [WIDTH-1:0] cmd_data_i,
    input wire clear_status_i,
    input wire status_preset_i,
    input wire instr_reset_i,
    output reg [WIDTH-1:0] rd_data_o,
    output reg rd_valid_o,
    output reg operation_summary_bit_o,
    output reg questionable_summary_bit_o
);

    // Edge detection against the previous live value, with filtering.
    function [WIDTH-1:0] srg_edges;
        input [WIDTH-1:0] prev;
        input [WIDTH-1:0] now;
        input [WIDTH-1:0] rise;
        input [WIDTH-1:0] fall;
        begin
            srg_edges = (~prev & now & rise) | (prev & ~now & fall);
        end
    endfunction

    // Summary of one group: any latched event whose mask bit is set.
    function srg_summary;
        input [WIDTH-1:0] events;
        input [WIDTH-1:0] mask;
        begin
            srg_summary = |(events & mask);
        end
    endfunction

    reg [WIDTH-1:0] operation_summary_bit_sync1_r;
    reg [WIDTH-1:0] operation_summary_bit_cond_r;
    reg [WIDTH-1:0] operation_summary_bit_prev_r;
    reg [WIDTH-1:0] questionable_summary_bit_sync1_r;
    reg [WIDTH-1:0] questionable_summary_bit_cond_r;
    reg [WIDTH-1:0] questionable_summary_bit_prev_r;
    reg [WIDTH-1:0] operation_summary_bit_enab_r;
    reg [WIDTH-1:0] operation_summary_bit_fall_r;
    reg [WIDTH-1:0] operation_summary_bit_rise_r;
    reg [WIDTH-1:0] operation_summary_bit_event_r;
    reg [WIDTH-1:0] questionable_summary_bit_enab_r;
    reg [WIDTH-1:0] questionable_summary_bit_fall_r;
    reg [WIDTH-1:0] questionable_summary_bit_rise_r;
    reg [WIDTH-1:0] questionable_summary_bit_event_r;
    reg [WIDTH-1:0] operation_summary_bit_event_nxt;
    reg [WIDTH-1:0] questionable_summary_bit_event_nxt;
    reg [WIDTH-1:0] rd_data_nxt;
    reg rd_valid_nxt;
    wire [WIDTH-1:0] operation_summary_bit_edges;
    wire [WIDTH-1:0] questionable_summary_bit_edges;
    wire [WIDTH-1:0] questionable_summary_bit_cond_view;
    wire wr_operation_summary_bit_enab;
    wire wr_operation_summary_bit_fall;
    wire wr_operation_summary_bit_rise;
    wire wr_questionable_summary_bit_enab;
    wire wr_questionable_summary_bit_fall;
    wire wr_questionable_summary_bit_rise;
    wire rd_operation_summary_bit_evt;
    wire rd_questionable_summary_bit_evt;

    // One strobe per writable register keeps each register block simple.
    assign wr_operation_summary_bit_enab = cmd_valid_i &&
        (cmd_code_i == `SRG_CMD_WR_OPERATION_SUMMARY_BIT_ENAB);
    assign wr_operation_summary_bit_fall = cmd_valid_i &&
        (cmd_code_i == `SRG_CMD_WR_OPERATION_SUMMARY_BIT_FALL);
    assign wr_operation_summary_bit_rise = cmd_valid_i &&
        (cmd_code_i == `SRG_CMD_WR_OPERATION_SUMMARY_BIT_RISE);
    assign wr_questionable_summary_bit_enab = cmd_valid_i &&
        (cmd_code_i == `SRG_CMD_WR_QUESTIONABLE_SUMMARY_BIT_ENAB);
    assign wr_questionable_summary_bit_fall = cmd_valid_i &&
        (cmd_code_i == `SRG_CMD_WR_QUESTIONABLE_SUMMARY_BIT_FALL);
    assign wr_questionable_summary_bit_rise = cmd_valid_i &&
        (cmd_code_i == `SRG_CMD_WR_QUESTIONABLE_SUMMARY_BIT_RISE);
    assign rd_operation_summary_bit_evt = cmd_valid_i &&
        (cmd_code_i == `SRG_CMD_RD_OPERATION_SUMMARY_BIT_EVENT);
    assign rd_questionable_summary_bit_evt = cmd_valid_i &&
        (cmd_code_i == `SRG_CMD_RD_QUESTIONABLE_SUMMARY_BIT_EVENT);
    // The questionable view is the synchronized condition alone; instr_reset_i
    // is not used, so instrument reset leaves the view and its history unchanged.
    assign questionable_summary_bit_cond_view = questionable_summary_bit_cond_r;
    assign operation_summary_bit_edges = srg_edges(operation_summary_bit_prev_r, operation_summary_bit_cond_r,
        operation_summary_bit_rise_r, operation_summary_bit_fall_r);
    assign questionable_summary_bit_edges = srg_edges(questionable_summary_bit_prev_r, questionable_summary_bit_cond_view,
        questionable_summary_bit_rise_r, questionable_summary_bit_fall_r);

    always @* begin
        operation_summary_bit_event_nxt = operation_summary_bit_event_r;
        questionable_summary_bit_event_nxt = questionable_summary_bit_event_r;
        // Clear first, then merge new edges, so a same-cycle edge survives.
        if (clear_status_i || rd_operation_summary_bit_evt) begin
            operation_summary_bit_event_nxt = `SRG_RST_EVENT;
        end
        if (clear_status_i || rd_questionable_summary_bit_evt) begin
            questionable_summary_bit_event_nxt = `SRG_RST_EVENT;
        end
        operation_summary_bit_event_nxt = operation_summary_bit_event_nxt | operation_summary_bit_edges;
        questionable_summary_bit_event_nxt = questionable_summary_bit_event_nxt | questionable_summary_bit_edges;
    end

    always @* begin
        rd_data_nxt = {WIDTH{1'b0}};
        rd_valid_nxt = 1'b0;
        if (cmd_valid_i) begin
            rd_valid_nxt = 1'b1;
            case (cmd_code_i)
                `SRG_CMD_RD_OPERATION_SUMMARY_BIT_EVENT: begin
                    rd_data_nxt = operation_summary_bit_event_r;
                end
                `SRG_CMD_RD_OPERATION_SUMMARY_BIT_COND: begin
                    rd_data_nxt = operation_summary_bit_cond_r;
                end
                `SRG_CMD_RD_OPERATION_SUMMARY_BIT_ENAB: begin
                    rd_data_nxt = operation_summary_bit_enab_r;
                end
                `SRG_CMD_RD_OPERATION_SUMMARY_BIT_FALL: begin
                    rd_data_nxt = operation_summary_bit_fall_r;
                end
                `SRG_CMD_RD_OPERATION_SUMMARY_BIT_RISE: begin
                    rd_data_nxt = operation_summary_bit_rise_r;
                end
                `SRG_CMD_RD_QUESTIONABLE_SUMMARY_BIT_EVENT: begin
                    rd_data_nxt = questionable_summary_bit_event_r;
                end
                `SRG_CMD_RD_QUESTIONABLE_SUMMARY_BIT_COND: begin
                    rd_data_nxt = questionable_summary_bit_cond_view;
                end
                `SRG_CMD_RD_QUESTIONABLE_SUMMARY_BIT_ENAB: begin
                    rd_data_nxt = questionable_summary_bit_enab_r;
                end
                `SRG_CMD_RD_QUESTIONABLE_SUMMARY_BIT_FALL: begin
                    rd_data_nxt = questionable_summary_bit_fall_r;
                end
                default: begin
                    rd_valid_nxt = 1'b0;
                end
            endcase
        end
    end

    // Source conditions come from outside this clock, so two flops each.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            operation_summary_bit_sync1_r <= {WIDTH{1'b0}};
            operation_summary_bit_cond_r <= {WIDTH{1'b0}};
            operation_summary_bit_prev_r <= {WIDTH{1'b0}};
        end else if (clk_en_i) begin
            operation_summary_bit_sync1_r <= operation_summary_bit_cond_src_i;
            operation_summary_bit_cond_r <= operation_summary_bit_sync1_r;
            operation_summary_bit_prev_r <= operation_summary_bit_cond_r;
        end
    end

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            questionable_summary_bit_sync1_r <= {WIDTH{1'b0}};
            questionable_summary_bit_cond_r <= {WIDTH{1'b0}};
            questionable_summary_bit_prev_r <= {WIDTH{1'b0}};
        end else if (clk_en_i) begin
            questionable_summary_bit_sync1_r <= questionable_summary_bit_cond_src_i;
            questionable_summary_bit_cond_r <= questionable_summary_bit_sync1_r;
            questionable_summary_bit_prev_r <= questionable_summary_bit_cond_view;
        end
    end

    // Preset has priority over a write that arrives in the same cycle.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            operation_summary_bit_enab_r <= `SRG_RST_ENAB;
        end else if (clk_en_i) begin
            if (status_preset_i) begin
                operation_summary_bit_enab_r <= `SRG_PRESET_ENAB;
            end else if (wr_operation_summary_bit_enab) begin
                operation_summary_bit_enab_r <= cmd_data_i;
            end
        end
    end

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            operation_summary_bit_fall_r <= `SRG_RST_FILTER;
        end else if (clk_en_i) begin
            if (status_preset_i) begin
                operation_summary_bit_fall_r <= `SRG_PRESET_FALL;
            end else if (wr_operation_summary_bit_fall) begin
                operation_summary_bit_fall_r <= cmd_data_i;
            end
        end
    end

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            operation_summary_bit_rise_r <= `SRG_RST_FILTER;
        end else if (clk_en_i) begin
            if (status_preset_i) begin
                operation_summary_bit_rise_r <= `SRG_PRESET_RISE;
            end else if (wr_operation_summary_bit_rise) begin
                operation_summary_bit_rise_r <= cmd_data_i;
            end
        end
    end

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            questionable_summary_bit_enab_r <= `SRG_RST_ENAB;
        end else if (clk_en_i) begin
            if (status_preset_i) begin
                questionable_summary_bit_enab_r <= `SRG_PRESET_ENAB;
            end else if (wr_questionable_summary_bit_enab) begin
                questionable_summary_bit_enab_r <= cmd_data_i;
            end
        end
    end

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            questionable_summary_bit_fall_r <= `SRG_RST_FILTER;
        end else if (clk_en_i) begin
            if (status_preset_i) begin
                questionable_summary_bit_fall_r <= `SRG_PRESET_FALL;
            end else if (wr_questionable_summary_bit_fall) begin
                questionable_summary_bit_fall_r <= cmd_data_i;
            end
        end
    end

    // The code space is full, so this filter has no readback command.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            questionable_summary_bit_rise_r <= `SRG_RST_FILTER;
        end else if (clk_en_i) begin
            if (status_preset_i) begin
                questionable_summary_bit_rise_r <= `SRG_PRESET_RISE;
            end else if (wr_questionable_summary_bit_rise) begin
                questionable_summary_bit_rise_r <= cmd_data_i;
            end
        end
    end

    // Event latches are never touched by instrument reset.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            operation_summary_bit_event_r <= `SRG_RST_EVENT;
            questionable_summary_bit_event_r <= `SRG_RST_EVENT;
        end else if (clk_en_i) begin
            operation_summary_bit_event_r <= operation_summary_bit_event_nxt;
            questionable_summary_bit_event_r <= questionable_summary_bit_event_nxt;
        end
    end

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_o <= {WIDTH{1'b0}};
            rd_valid_o <= 1'b0;
            operation_summary_bit_o <= 1'b0;
            questionable_summary_bit_o <= 1'b0;
        end else if (clk_en_i) begin
            rd_data_o <= rd_data_nxt;
            rd_valid_o <= rd_valid_nxt;
            operation_summary_bit_o <=
                srg_summary(operation_summary_bit_event_nxt, operation_summary_bit_enab_r);
            questionable_summary_bit_o <=
                srg_summary(questionable_summary_bit_event_nxt, questionable_summary_bit_enab_r);
        end
    end

endmodule // srg_status_groups

// [dv/srg_status_groups_assertions.sv]
// Port checker for the status register groups.
`timescale 1ns/1ps
`include "srg_defines.vh"
module srg_status_groups_assertions #(
    parameter WIDTH = 16
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire clk_en_i,
    input wire [WIDTH-1:0] operation_summary_bit_cond_src_i,
    input wire [WIDTH-1:0] questionable_summary_bit_cond_src_i,
    input wire cmd_valid_i,
    input wire [`SRG_CMD_W-1:0] cmd_code_i,
    input wire [WIDTH-1:0] cmd_data_i,
    input wire clear_status_i,
    input wire status_preset_i,
    input wire instr_reset_i,
    input wire [WIDTH-1:0] rd_data_o,
    input wire rd_valid_o,
    input wire operation_summary_bit_o,
    input wire questionable_summary_bit_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    wire take = cmd_valid_i && clk_en_i;
    wire rd_cmd = cmd_code_i >= `SRG_CMD_RD_OPERATION_SUMMARY_BIT_EVENT;
    // A write followed at once by its read returns the written word.
    property wr_rd(logic [3:0] w, logic [3:0] r);
        take && !status_preset_i && cmd_code_i == w ##1
        take && cmd_code_i == r |=> rd_data_o == $past(cmd_data_i, 2);
    endproperty
    AST_RD_VALID: assert property (take && rd_cmd |=> rd_valid_o)
        else $error("read gave no answer");
    AST_NO_RD: assert property (clk_en_i && !(take && rd_cmd) |=> !rd_valid_o)
        else $error("answer without read");
    AST_PRESET_SUM: assert property (clk_en_i && status_preset_i ##1
        clk_en_i && !(cmd_valid_i && (cmd_code_i == 1 || cmd_code_i == 4))
        |=> !operation_summary_bit_o && !questionable_summary_bit_o)
        else $error("summary set after preset");
    AST_PRESET_RISE: assert property (clk_en_i && status_preset_i ##1
        take && cmd_code_i == `SRG_CMD_RD_OPERATION_SUMMARY_BIT_RISE |=> rd_data_o == 16'hffff)
        else $error("rise filter not preset");
    AST_OP_ENAB: assert property (wr_rd(4'h1, 4'h9))
        else $error("enable readback wrong");
    AST_OP_FALL: assert property (wr_rd(4'h2, 4'ha))
        else $error("fall readback wrong");
    AST_OP_RISE: assert property (wr_rd(4'h3, 4'hb))
        else $error("rise readback wrong");
    AST_Q_ENAB: assert property (wr_rd(4'h4, 4'he))
        else $error("enable readback wrong");
    AST_Q_FALL: assert property (wr_rd(4'h5, 4'hf))
        else $error("fall readback wrong");
    cover property (take && cmd_code_i == `SRG_CMD_RD_OPERATION_SUMMARY_BIT_EVENT ##1 rd_valid_o);
    cover property ($rose(operation_summary_bit_o));
    cover property ($rose(questionable_summary_bit_o));
endmodule // srg_status_groups_assertions
bind srg_status_groups srg_status_groups_assertions #(.WIDTH(WIDTH)) i_chk (.*);

// [dv/srg_status_groups_tb.sv]
// Self-checking bench for the status register groups.
`timescale 1ns/1ps
`include "srg_defines.vh"
module srg_status_groups_tb;
    logic ref_clk_i = 0, reset_i = 1, cmd_valid_i = 0, clk_en_i = 1;
    logic clear_status_i = 0, status_preset_i = 0, instr_reset_i = 0;
    logic [3:0] cmd_code_i = 4'h0;
    logic [15:0] cmd_data_i = 16'h0, operation_summary_bit_cond_src_i = 16'h0;
    logic [15:0] questionable_summary_bit_cond_src_i = 16'h0, rd_data_o;
    logic rd_valid_o, operation_summary_bit_o, questionable_summary_bit_o;
    int err_total = 0, checked = 0, cycles = 0;
    srg_status_groups i_srg_status_groups (.*);
    always #4 ref_clk_i = ~ref_clk_i;
    task print_verdict;
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // The ceiling is far above the roughly 80 cycles the run needs.
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            print_verdict;
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Leaves the strobe high so that commands can follow back to back.
    task cmd(input logic [3:0] c, input logic [15:0] d);
        cmd_valid_i = 1'b1;
        cmd_code_i = c;
        cmd_data_i = d;
        @(negedge ref_clk_i);
    endtask
    task rd(input logic [3:0] c, input logic [15:0] exp);
        cmd(c, 16'h0);
        chk((rd_valid_o === 1'b1) ? rd_data_o : 16'hdead, exp);
    endtask
    task idle(input int n);
        cmd_valid_i = 1'b0;
        repeat (n) @(negedge ref_clk_i);
    endtask
    task pulse(input logic [2:0] v);
        cmd_valid_i = 1'b0;
        {clear_status_i, status_preset_i, instr_reset_i} = v;
        @(negedge ref_clk_i);
        {clear_status_i, status_preset_i, instr_reset_i} = 3'h0;
    endtask
    task reset_values;
        for (int c = 7; c < 16; c++) rd(c[3:0], 16'h0);
    endtask
    task readback;
        for (int i = 1; i < 6; i++) begin
            cmd(i[3:0], 16'h1111 * i[15:0]);
            rd(i[3:0] + ((i > 3) ? 4'ha : 4'h8), 16'h1111 * i[15:0]);
        end
    endtask
    task operation_summary_bit_edges;
        cmd(4'h1, 16'h0008);
        cmd(4'h3, 16'h0005);
        cmd(4'h2, 16'h0006);
        operation_summary_bit_cond_src_i = 16'h000f;
        idle(5);
        chk({15'h0, operation_summary_bit_o}, 16'h0);
        rd(4'h8, 16'h000f);
        cmd(4'h1, 16'h0001);
        idle(2);
        chk({15'h0, operation_summary_bit_o}, 16'h1);
        rd(4'h7, 16'h0005);
        rd(4'h7, 16'h0000);
        operation_summary_bit_cond_src_i = 16'h0;
        idle(5);
        rd(4'h8, 16'h0000);
        rd(4'h7, 16'h0006);
        // The rising edge reaches the latch at the edge that takes the read.
        operation_summary_bit_cond_src_i = 16'h0001;
        idle(2);
        rd(4'h7, 16'h0000);
        rd(4'h7, 16'h0001);
        // A write while the clock enable is low must not land.
        clk_en_i = 1'b0;
        cmd(4'h1, 16'hffff);
        clk_en_i = 1'b1;
        rd(4'h9, 16'h0001);
    endtask
    task questionable_summary_bit_flow;
        pulse(3'h2);
        rd(4'hb, 16'hffff);
        rd(4'hf, 16'h0000);
        rd(4'he, 16'h0000);
        questionable_summary_bit_cond_src_i = 16'h0010;
        cmd(4'h4, 16'h0010);
        idle(5);
        chk({15'h0, questionable_summary_bit_o}, 16'h1);
        pulse(3'h1);
        idle(2);
        chk({15'h0, questionable_summary_bit_o}, 16'h1);
        rd(4'hd, 16'h0010);
        pulse(3'h4);
        idle(2);
        chk({15'h0, questionable_summary_bit_o}, 16'h0);
        rd(4'he, 16'h0010);
        rd(4'hc, 16'h0000);
    endtask
    initial begin
        repeat (10) @(negedge ref_clk_i);
        reset_i = 1'b0;
        reset_values;
        readback;
        operation_summary_bit_edges;
        questionable_summary_bit_flow;
        idle(3);
        print_verdict;
    end
endmodule // srg_status_groups_tb
